// [pkg/ccd_defines.svh]
// constants of the configuration command decoder: opcodes, offsets, fields, counts
`ifndef CCD_DEFINES_SVH
`define CCD_DEFINES_SVH

// opcodes
`define CCD_OP_FEAT_READ   8'hFB
`define CCD_OP_CFG_READ    8'h73
`define CCD_OP_USER_READ   8'hCA
`define CCD_OP_SET_DONE    8'h5E
`define CCD_OP_FUSE_LOCK   8'hF9
`define CCD_OP_FUSE_READ   8'hFA
`define CCD_OP_LEAVE_CFG   8'h26
`define CCD_OP_ERASE       8'h0E
`define CCD_OP_NOOP        8'hFF
`define CCD_OP_RECONFIG    8'h79
`define CCD_OP_READ_PROT   8'hCE
`define CCD_OP_FULL_PROT   8'hCF
`define CCD_OP_UNIQUE_RD   8'h19
`define CCD_OP_SRAM_LOAD   8'h7A
`define CCD_OP_KEY_STORE   8'hF1
`define CCD_OP_KEY_FETCH   8'hF2
`define CCD_OP_KEY_PRESENT 8'hBC

// operand lengths in bytes
`define CCD_OPND_LONG      4'h3
`define CCD_OPND_SHORT     4'h2
// page count field width, page geometry and index of the last key byte
`define CCD_CNT_BITS       14
`define CCD_PAGE_BYTES     16
`define CCD_PAGES          4
`define CCD_KEY_LAST       18'h0_0007

// register byte addresses
`define CCD_REG_FEAT       8'h00
`define CCD_REG_MODE       8'h04
`define CCD_REG_STATUS     8'h08
`define CCD_REG_MEMWR      8'h0C
`define CCD_REG_KEY_LO     8'h10
`define CCD_REG_KEY_HI     8'h14

// field positions
`define CCD_FEAT_KEYEN     0
`define CCD_MODE_OFFLINE   0
`define CCD_MODE_TRANSP    1
`define CCD_FUSE_SRAM      0
`define CCD_FUSE_FEAT      1

// reset values
`define CCD_FEAT_RST       16'h0000
`define CCD_KEY_RST        64'h0000_0000_0000_0000
// per-die number, value arbitrary
`define CCD_UID_VALUE      64'h0123_4567_89AB_CDEF

`endif

// [pkg/ccd_pkg.sv]
// types of the configuration command decoder
package ccd_pkg;

	// state of the decoder apart from the page store, registered in one place
	typedef struct packed {
		logic        clkS1;      // link clock synchroniser
		logic        clkS2;
		logic        clkPrev;    // for edge detection
		logic        selS1;      // frame select synchroniser, active low
		logic        selS2;
		logic        mosiS1;     // serial data in synchroniser
		logic        mosiS2;
		logic [2:0]  bitCnt;     // bit within byte
		logic [7:0]  rxShift;    // incoming byte
		logic [7:0]  txShift;    // outgoing byte
		logic        miso;       // serial data out
		logic [3:0]  byteCnt;    // byte within frame, saturating
		logic [17:0] dataCnt;    // data bytes seen after operands
		logic [7:0]  opcode;
		logic [23:0] opnd;
		logic [63:0] keyAcc;     // incoming key bytes
		logic [15:0] featBits;   // 16 feature bits
		logic        offline;
		logic        transparent;
		logic        done;
		logic        readProt;
		logic        fullProt;
		logic        unlocked;
		logic [7:0]  fuse;
		logic [63:0] key;
		logic [31:0] rdata;
		logic        reconfig;
		logic        wake;
		logic [7:0]  sramByte;
		logic        sramValid;
	} ccd_state_s;

endpackage : ccd_pkg

// [design/ccd_top.sv]
// configuration command decoder: serial command link, register port, state
`timescale 1ns/1ns
`default_nettype none
`include "ccd_defines.svh"

// Functional notes
// - config page read returns count, low 14 bits
// - user page read, same count handling
// - set-done command sets nonvolatile done bit; here reset clears it
// - fuse lock needs both matching bits
// - fuse read returns same layout byte
// - leave-config exits offline and transparent modes
// - leaving offline mode starts reconfiguration
// - no-operation only wakes the device
// - reconfigure command forces full reconfiguration
// - readout protect sets security bit
// - full protect sets enhanced security bit
// - unique number read returns eight bytes
// - sram load streams bitstream bytes out
// - key store keeps eight written bytes
// - key fetch returns stored key bytes
// - matching presented key unlocks when enabled
// - unlock lasts until leave or reconfigure
// - multi-page read repeats first page
module ccd_top (
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic        ce,
	input  wire logic        linkClk,
	input  wire logic        linkSel_b,
	input  wire logic        linkMosi,
	output logic             linkMiso,
	input  wire logic [7:0]  regAddr,
	input  wire logic [31:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [31:0] regRdata,
	output logic             doneBit,
	output logic             unlocked,
	output logic             reconfigStart,
	output logic             wakeUp,
	output logic      [7:0]  sramByte,
	output logic             sramValid
);

	ccd_pkg::ccd_state_s s_q;   // registered state
	ccd_pkg::ccd_state_s s_d;   // next state

	// page store: two sectors of four pages, filled by software
	logic [7:0] pageMem [0:2*`CCD_PAGES*`CCD_PAGE_BYTES-1];

	logic        rise;       // sampled link clock rising edge
	logic        fall;       // sampled link clock falling edge
	logic        byteDone;   // eighth bit of a byte taken
	logic [7:0]  rxByte;     // byte just completed
	logic [3:0]  opLen;      // operand bytes of current opcode
	logic        lastOp;     // completed byte is last operand
	logic        dataByte;   // completed byte is write data
	logic [23:0] opndNew;    // operands including this byte
	logic [23:0] opndUse;
	logic        permit;     // programming allowed by key state
	logic        known;      // opcode is one this block handles
	logic        execDone;
	logic        execRdProt;
	logic        execFullProt;
	logic        execLeave;
	logic        execRefresh;
	logic        execBypass;
	logic        fuseExec;
	logic        keyMatch;
	logic [17:0] nextIdx;    // index of next data byte to send

	// one byte of read data for a given opcode and data index
	function automatic logic [7:0] readByte(input logic [7:0] op, input logic [17:0] idx,
						input logic [23:0] opnd, input logic [15:0] feat,
						input logic [7:0] fuse, input logic [63:0] key,
						input logic [7:0] pageData);
		logic [7:0] r;
		r = 8'h00;
		case (op)
			`CCD_OP_FEAT_READ:  r = (idx == 18'h0_0000) ? feat[15:8] : feat[7:0];
			`CCD_OP_FUSE_READ:  r = fuse;
			// msb byte first; only the low byte of the shifted word is kept
			`CCD_OP_UNIQUE_RD:  r = 8'(`CCD_UID_VALUE >> (8 * (7 - idx[2:0])));
			// key goes out in the same byte order as it was stored
			`CCD_OP_KEY_FETCH:  r = 8'(key >> (8 * (7 - idx[2:0])));
			`CCD_OP_CFG_READ,
			`CCD_OP_USER_READ: begin
				// beyond the requested count the line idles at zero
				if (idx[17:4] < opnd[`CCD_CNT_BITS-1:0]) begin
					r = pageData;
				end
			end
			default:            r = 8'h00;
		endcase
		return r;
	endfunction : readByte

	// page and byte addressed by the next outgoing index
	// the byte to send is fetched half a link clock ahead of its first bit,
	// the store read itself is combinational and lands in txShift in that same sys clock
	// limitation: no address pointer, every read begins at page 0
	logic [13:0] pageSeq;
	logic [1:0]  pageNo;
	logic        userSector;
	always_comb begin
		pageSeq    = nextIdx[17:4];
		// first page goes out twice, then the pointer walks on
		pageNo     = (pageSeq == 14'h0000) ? 2'h0 : 2'(pageSeq - 14'h0001);
		userSector = (s_q.opcode == `CCD_OP_USER_READ) ||
				(s_q.byteCnt == 4'h0 && rxByte == `CCD_OP_USER_READ);
	end

	// link edge and byte decode
	always_comb begin
		rise     = s_q.clkS2 && !s_q.clkPrev && !s_q.selS2;
		fall     = !s_q.clkS2 && s_q.clkPrev && !s_q.selS2;
		byteDone = rise && (s_q.bitCnt == 3'h7);
		rxByte   = {s_q.rxShift[6:0], s_q.mosiS2};
		opLen    = (s_q.opcode == `CCD_OP_LEAVE_CFG || s_q.opcode == `CCD_OP_RECONFIG) ?
				`CCD_OPND_SHORT : `CCD_OPND_LONG;
		lastOp   = byteDone && (s_q.byteCnt == opLen);
		dataByte = byteDone && (s_q.byteCnt > opLen);
		opndNew  = {s_q.opnd[15:0], rxByte};
		opndUse  = lastOp ? opndNew : s_q.opnd;
		nextIdx  = lastOp ? 18'h0_0000 : s_q.dataCnt + 18'h0_0001;
		permit   = !s_q.featBits[`CCD_FEAT_KEYEN] || s_q.unlocked;
		case (s_q.opcode)
			`CCD_OP_FEAT_READ, `CCD_OP_CFG_READ, `CCD_OP_USER_READ, `CCD_OP_SET_DONE,
			`CCD_OP_FUSE_LOCK, `CCD_OP_FUSE_READ, `CCD_OP_LEAVE_CFG, `CCD_OP_ERASE,
			`CCD_OP_NOOP, `CCD_OP_RECONFIG, `CCD_OP_READ_PROT, `CCD_OP_FULL_PROT,
			`CCD_OP_UNIQUE_RD, `CCD_OP_SRAM_LOAD, `CCD_OP_KEY_STORE, `CCD_OP_KEY_FETCH,
			`CCD_OP_KEY_PRESENT: known = 1'b1;
			default:             known = 1'b0;
		endcase
		// commands without write data act on their last operand byte
		execDone     = lastOp && permit && s_q.opcode == `CCD_OP_SET_DONE;
		execRdProt   = lastOp && permit && s_q.opcode == `CCD_OP_READ_PROT;
		execFullProt = lastOp && permit && s_q.opcode == `CCD_OP_FULL_PROT;
		execLeave    = lastOp && s_q.opcode == `CCD_OP_LEAVE_CFG && opndNew[15:0] == 16'h0000;
		execRefresh  = lastOp && s_q.opcode == `CCD_OP_RECONFIG && opndNew[15:0] == 16'h0000;
		execBypass   = lastOp && s_q.opcode == `CCD_OP_NOOP && opndNew == 24'hFF_FFFF;
		fuseExec     = dataByte && permit && s_q.opcode == `CCD_OP_FUSE_LOCK &&
				s_q.dataCnt == 18'h0_0000;
		keyMatch     = dataByte && s_q.opcode == `CCD_OP_KEY_PRESENT &&
				s_q.dataCnt == `CCD_KEY_LAST && s_q.featBits[`CCD_FEAT_KEYEN] &&
				{s_q.keyAcc[55:0], rxByte} == s_q.key;
	end

	// next state
	always_comb begin
		s_d = s_q;
		// two flops on every link input; only the second is looked at
		s_d.clkS1     = linkClk;
		s_d.clkS2     = s_q.clkS1;
		s_d.clkPrev   = s_q.clkS2;
		s_d.selS1     = linkSel_b;
		s_d.selS2     = s_q.selS1;
		s_d.mosiS1    = linkMosi;
		s_d.mosiS2    = s_q.mosiS1;
		// pulses last one cycle
		s_d.reconfig  = 1'b0;
		s_d.wake      = 1'b0;
		s_d.sramValid = 1'b0;
		s_d.rdata     = 32'h0000_0000;

		if (s_q.selS2) begin
			// frame idle: rearm framing so next frame starts at its opcode
			s_d.bitCnt  = 3'h0;
			s_d.byteCnt = 4'h0;
			s_d.dataCnt = 18'h0_0000;
			s_d.miso    = 1'b0;
			s_d.txShift = 8'h00;
		end else if (rise) begin
			s_d.rxShift = rxByte;
			s_d.bitCnt  = s_q.bitCnt + 3'h1;
		end else if (fall) begin
			// present msb ahead of the next rising edge
			s_d.miso    = s_q.txShift[7];
			s_d.txShift = {s_q.txShift[6:0], 1'b0};
		end

		if (byteDone) begin
			if (s_q.byteCnt != 4'hF) begin
				s_d.byteCnt = s_q.byteCnt + 4'h1;
			end
			if (s_q.byteCnt == 4'h0) begin
				s_d.opcode = rxByte;
				s_d.opnd   = 24'h00_0000;
			end else if (s_q.byteCnt <= opLen) begin
				s_d.opnd = opndNew;
			end
			if (dataByte && s_q.dataCnt != 18'h3_FFFF) begin
				s_d.dataCnt = s_q.dataCnt + 18'h0_0001;
			end
			if (lastOp || dataByte) begin
				s_d.txShift = readByte(s_q.opcode, nextIdx, opndUse, s_q.featBits,
						s_q.fuse, s_q.key,
						pageMem[{userSector, pageNo, nextIdx[3:0]}]);
			end
			if (dataByte) begin
				s_d.keyAcc = {s_q.keyAcc[55:0], rxByte};
			end
		end

		// register port writes; link commands below take precedence
		if (regWr) begin
			case (regAddr)
				`CCD_REG_FEAT: s_d.featBits = regWdata[15:0];
				`CCD_REG_MODE: begin
					s_d.offline     = regWdata[`CCD_MODE_OFFLINE];
					s_d.transparent = regWdata[`CCD_MODE_TRANSP];
				end
				default:       s_d = s_d; // page store and unmapped: no state here
			endcase
		end

		if (execDone) begin
			s_d.done = 1'b1;
		end
		if (execRdProt) begin
			s_d.readProt = 1'b1;
		end
		if (execFullProt) begin
			s_d.fullProt = 1'b1;
		end
		if (execBypass) begin
			s_d.wake = 1'b1;
		end
		if (execLeave) begin
			s_d.offline     = 1'b0;
			s_d.transparent = 1'b0;
			s_d.unlocked    = 1'b0;
			// only offline exit reloads; host must have erased sram first
			s_d.reconfig    = s_q.offline;
		end
		if (execRefresh) begin
			// same effect as pulling the reconfig_request_pin
			s_d.reconfig    = 1'b1;
			s_d.offline     = 1'b0;
			s_d.transparent = 1'b0;
			s_d.unlocked    = 1'b0;
		end
		if (fuseExec) begin
			// a space locks only when both of its bits are set
			s_d.fuse[3:0] = s_q.fuse[3:0] | (rxByte[3:0] & rxByte[7:4]);
			s_d.fuse[7:4] = s_q.fuse[7:4] | (rxByte[3:0] & rxByte[7:4]);
		end
		if (dataByte && permit && s_q.opcode == `CCD_OP_KEY_STORE &&
				s_q.dataCnt == `CCD_KEY_LAST && !s_q.fuse[`CCD_FUSE_FEAT]) begin
			s_d.key = {s_q.keyAcc[55:0], rxByte};
		end
		if (keyMatch) begin
			s_d.unlocked = 1'b1;
		end
		if (dataByte && permit && s_q.opcode == `CCD_OP_SRAM_LOAD &&
				!s_q.fuse[`CCD_FUSE_SRAM]) begin
			// length is open: every byte until the frame ends
			s_d.sramByte  = rxByte;
			s_d.sramValid = 1'b1;
		end

		// register port read, answered in the next cycle only
		if (regRd) begin
			case (regAddr)
				`CCD_REG_FEAT:   s_d.rdata = {16'h0000, s_q.featBits};
				`CCD_REG_MODE:   s_d.rdata = {30'h0000_0000, s_q.transparent, s_q.offline};
				`CCD_REG_STATUS: s_d.rdata = {16'h0000, s_q.fuse, 4'h0, s_q.unlocked,
						s_q.fullProt, s_q.readProt, s_q.done};
				`CCD_REG_KEY_LO: s_d.rdata = s_q.key[31:0];
				`CCD_REG_KEY_HI: s_d.rdata = s_q.key[63:32];
				default:         s_d.rdata = 32'h0000_0000;
			endcase
		end
	end

	// state register; clock enable freezes everything
	// reset wins over ce so a frozen block can still be brought up
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			s_q          <= '0;
			s_q.clkS1    <= 1'b0;
			s_q.selS1    <= 1'b1;
			s_q.selS2    <= 1'b1;
			s_q.featBits <= `CCD_FEAT_RST;
			s_q.key      <= `CCD_KEY_RST;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	// page store writes: address in bits 14:8, byte in 7:0
	always_ff @(posedge clk_sys) begin
		if (ce && regWr && regAddr == `CCD_REG_MEMWR) begin
			pageMem[regWdata[14:8]] <= regWdata[7:0];
		end
	end

	// outputs straight from the state register
	assign linkMiso      = s_q.miso;
	assign regRdata      = s_q.rdata;
	assign doneBit       = s_q.done;
	assign unlocked      = s_q.unlocked;
	assign reconfigStart = s_q.reconfig;
	assign wakeUp        = s_q.wake;
	assign sramByte      = s_q.sramByte;
	assign sramValid     = s_q.sramValid;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);

	done_set_a: assert property (ce && execDone |=> doneBit)
		else $error("done bit not set by set-done command");
	fuse_pair_a: assert property (ce && fuseExec |=> s_q.fuse[3:0] ==
			($past(s_q.fuse[3:0]) | ($past(rxByte[3:0]) & $past(rxByte[7:4]))))
		else $error("fuse lock did not follow bit pairs");
	leave_exit_a: assert property (ce && execLeave |=> !s_q.offline && !s_q.transparent)
		else $error("modes still set after leave command");
	leave_reconf_a: assert property (ce && execLeave && s_q.offline |=>
			reconfigStart ##1 !reconfigStart)
		else $error("no single reconfig pulse after offline exit");
	wake_pulse_a: assert property (ce && execBypass |=> wakeUp ##1 !wakeUp)
		else $error("no-operation did not give one wake pulse");
	refresh_reconf_a: assert property (ce && execRefresh |=> reconfigStart && !unlocked)
		else $error("reconfigure command did not reconfigure and relock");
	prot_bits_a: assert property (ce && (execRdProt || execFullProt) |=>
			s_q.readProt || s_q.fullProt)
		else $error("protect command did not set a security bit");
	key_unlock_a: assert property (ce && keyMatch && !execRefresh |=> unlocked)
		else $error("matching key did not unlock");
	unknown_hold_a: assert property (ce && lastOp && !known |=>
			$stable({s_q.done, s_q.readProt, s_q.fullProt, s_q.unlocked, s_q.fuse}))
		else $error("unknown opcode changed state");

endmodule : ccd_top
`default_nettype wire

// [bench/ccd_link_master.sv]
// link master model: frames, bytes and idle levels of the serial command link
`timescale 1ns/1ns
`default_nettype none
module ccd_link_master (
	input  wire logic clk_sys,
	output logic      linkClk,
	output logic      linkSel_b,
	output logic      linkMosi,
	input  wire logic linkMiso
);
	// idle: deselected, clock parked low between frames
	initial begin
		linkClk   = 1'b0;
		linkSel_b = 1'b1;
		linkMosi  = 1'b0;
	end

	// select, then a half period of setup
	task automatic start();
		@(posedge clk_sys) linkSel_b <= 1'b0;
		repeat (8) @(posedge clk_sys);
	endtask : start

	// one byte msb first; 8 sys clocks per half period gives 160 ns
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			linkMosi <= tx[i];
			repeat (8) @(posedge clk_sys);
			linkClk <= 1'b1;
			// reply changed after the fall, settled long before the rise
			#1 rx[i] = linkMiso;
			repeat (8) @(posedge clk_sys);
			linkClk <= 1'b0;
		end
	endtask : xfer

	// deselect; the released line shows the inverse of its last bit
	task automatic stop();
		repeat (8) @(posedge clk_sys);
		linkSel_b <= 1'b1;
		linkMosi  <= ~linkMosi;
	endtask : stop
endmodule : ccd_link_master
`default_nettype wire

// [bench/tb.sv]
// self-checking bench of the configuration command decoder
`timescale 1ns/1ns
`default_nettype none
`include "ccd_defines.svh"
module tb;
	logic        clk_sys, rst_b, ce, linkClk, linkSel_b, linkMosi, linkMiso;
	logic        regWr, regRd, doneBit, unlocked, reconfigStart, wakeUp, sramValid;
	logic [7:0]  regAddr, sramByte;
	logic [31:0] regWdata, regRdata, d;
	logic [7:0]  txQ[$], rxQ[$], sramQ[$];
	int          err_count, check_count, rcCnt, wkCnt, rc0;
	// fixed test key, any value serves
	localparam logic [63:0] KEY = 64'hF0E1_D2C3_B4A5_9687;

	ccd_top i_ccd_top (.clk_sys, .rst_b, .ce, .linkClk, .linkSel_b, .linkMosi, .linkMiso,
		.regAddr, .regWdata, .regWr, .regRd, .regRdata, .doneBit, .unlocked,
		.reconfigStart, .wakeUp, .sramByte, .sramValid);
	ccd_link_master i_ccd_link_master (.clk_sys, .linkClk, .linkSel_b, .linkMosi, .linkMiso);

	// clock and time-zero inputs; ce stays high throughout
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		{rst_b, regWr, regRd, regAddr, regWdata} = '0;
		ce = 1'b1;
	end
	// pulse counters and captured bitstream bytes
	always @(posedge clk_sys) begin
		if (reconfigStart === 1'b1) rcCnt <= rcCnt + 1;
		if (wakeUp === 1'b1) wkCnt <= wkCnt + 1;
		if (sramValid === 1'b1) sramQ.push_back(sramByte);
	end

	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic doReset();
		@(posedge clk_sys) rst_b <= 1'b0;
		repeat (10) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk_sys);
	endtask : doReset
	task automatic regWrite(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		regAddr  <= a;
		regWdata <= v;
		regWr    <= 1'b1;
		@(posedge clk_sys) regWr <= 1'b0;
	endtask : regWrite
	// read data stand only in the cycle after the strobe
	task automatic regRead(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk_sys);
		regAddr <= a;
		regRd   <= 1'b1;
		@(posedge clk_sys) regRd <= 1'b0;
		#1 v = regRdata;
	endtask : regRead
	// whole frame from txQ, replies into rxQ, then time for effects to land
	task automatic frame();
		logic [7:0] r;
		rxQ = {};
		i_ccd_link_master.start();
		foreach (txQ[i]) begin
			i_ccd_link_master.xfer(txQ[i], r);
			rxQ.push_back(r);
		end
		i_ccd_link_master.stop();
		repeat (12) @(posedge clk_sys);
	endtask : frame
	task automatic cmd(input logic [7:0] op);
		txQ = {op, 8'h00, 8'h00, 8'h00};
		frame();
	endtask : cmd
	task automatic cmdKey(input logic [7:0] op, input logic [63:0] k);
		txQ = {op, 8'h00, 8'h00, 8'h00};
		for (int i = 7; i >= 0; i--) txQ.push_back(k[i*8+:8]);
		frame();
	endtask : cmdKey
	function automatic logic [63:0] rx64();
		logic [63:0] v;
		for (int i = 4; i < 12; i++) v = {v[55:0], rxQ[i]};
		return v;
	endfunction : rx64
	task automatic status(input logic [31:0] exp);
		regRead(`CCD_REG_STATUS, d);
		check("status", d, exp);
	endtask : status

	// done, both protect bits, unknown opcode
	task automatic t_bits();
		regRead(8'h40, d);
		check("unmapped", d, 32'h0000_0000);
		cmd(`CCD_OP_SET_DONE);
		check("doneBit", doneBit, 1'b1);
		cmd(`CCD_OP_READ_PROT);
		status(32'h0000_0003);
		doReset();
		cmd(`CCD_OP_FULL_PROT);
		status(32'h0000_0004);
		cmd(8'h55);
		status(32'h0000_0004);
	endtask : t_bits

	// fuse pairs, fuse readback, bitstream stream
	task automatic t_fuse();
		doReset();
		txQ = {`CCD_OP_SRAM_LOAD, 8'h00, 8'h00, 8'h00, 8'hA5, 8'h3C};
		frame();
		check("sram", {sramQ.size(), sramQ[0], sramQ[1]}, {32'd2, 16'hA53C});
		txQ = {`CCD_OP_FUSE_LOCK, 8'h00, 8'h00, 8'h00, 8'h13};
		frame();
		status(32'h0000_1100);
		txQ = {`CCD_OP_FUSE_READ, 8'h00, 8'h00, 8'h00, 8'h00};
		frame();
		check("fuseRead", rxQ[4], 8'h11);
	endtask : t_fuse

	// key store and fetch, unlock and its two ends, no-operation, unique number
	task automatic t_key();
		doReset();
		cmdKey(`CCD_OP_KEY_STORE, KEY);
		regRead(`CCD_REG_KEY_HI, d);
		check("keyHi", d, KEY[63:32]);
		regRead(`CCD_REG_KEY_LO, d);
		check("keyLo", d, KEY[31:0]);
		cmdKey(`CCD_OP_KEY_FETCH, 64'h0);
		check("keyFetch", rx64(), KEY);
		regWrite(`CCD_REG_FEAT, 32'h0000_0001);
		// feature bits read back over the link, msb byte first
		txQ = {`CCD_OP_FEAT_READ, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		frame();
		check("featRead", {rxQ[4], rxQ[5]}, 16'h0001);
		cmdKey(`CCD_OP_KEY_PRESENT, KEY ^ 64'h1);
		check("badKey", unlocked, 1'b0);
		cmdKey(`CCD_OP_KEY_PRESENT, KEY);
		check("goodKey", unlocked, 1'b1);
		rc0 = rcCnt;
		txQ = {`CCD_OP_RECONFIG, 8'h00, 8'h00};
		frame();
		check("refresh", {rcCnt - rc0, 31'h0, unlocked}, 64'h1_0000_0000);
		cmdKey(`CCD_OP_KEY_PRESENT, KEY);
		regWrite(`CCD_REG_MODE, 32'h0000_0003);
		txQ = {`CCD_OP_ERASE, 8'h01, 8'h00, 8'h00};
		frame();
		rc0 = rcCnt;
		txQ = {`CCD_OP_LEAVE_CFG, 8'h00, 8'h00};
		frame();
		check("leave", {rcCnt - rc0, 31'h0, unlocked}, 64'h1_0000_0000);
		regRead(`CCD_REG_MODE, d);
		check("mode", d, 32'h0000_0000);
		rc0 = wkCnt;
		txQ = {`CCD_OP_NOOP, 8'hFF, 8'hFF, 8'hFF};
		frame();
		check("wake", {wkCnt - rc0, 32'(rcCnt)}, {32'd1, 32'd2});
		cmdKey(`CCD_OP_UNIQUE_RD, 64'h0);
		check("unique", rx64(), `CCD_UID_VALUE);
	endtask : t_key

	// page reads of both sectors, count from the low 14 bits only
	task automatic t_pages();
		for (int s = 0; s < 2; s++)
			for (int b = 0; b < 16; b++)
				regWrite(`CCD_REG_MEMWR, {17'h0, s[0], 2'b00, b[3:0], s[0], 3'h2, b[3:0]});
		for (int k = 0; k < 2; k++) begin
			txQ = {k ? `CCD_OP_USER_READ : `CCD_OP_CFG_READ, 8'h00, 8'hC0, 8'h02};
			repeat (33) txQ.push_back(8'h00);
			frame();
			for (int i = 0; i < 32; i++)
				check("page", rxQ[4+i], {k[0], 3'h2, i[3:0]});
			check("pageEnd", rxQ[36], 8'h00);
		end
	endtask : t_pages

	task automatic summarize();
		if (err_count == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : summarize

	// main sequence
	initial begin
		doReset();
		check("outs", {doneBit, unlocked, reconfigStart, wakeUp, sramValid}, 5'h00);
		t_bits();
		t_fuse();
		t_key();
		t_pages();
		summarize();
	end
	// watchdog, well beyond the expected 26k cycles
	initial begin
		#600_000;
		err_count++;
		summarize();
	end
endmodule : tb
`default_nettype wire
